// File: hw/pcn_detect.v
`default_nettype none

// Per-pin mismatch detection against the last-read latch.
module pcn_detect (
  input wire [15:0] pin_sync,
  input wire [15:0] last_read,
  input wire [15:0] enable,
  input wire [15:0] analog,
  output wire [15:0] mismatch,
  output wire mismatch_any
);
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_cmp
      // An analog pin has no digital input, so it never compares.
      assign mismatch[i] = enable[i] & ~analog[i] & (pin_sync[i] ^ last_read[i]);
    end
  endgenerate

  // All mismatches feed one shared flag.
  assign mismatch_any = |mismatch;
endmodule

`default_nettype wire

// File: hw/pcn_sync.v
`default_nettype none

// Two-flop synchroniser, one generate instance per pin bit.
module pcn_sync (
  input wire pclk,
  input wire presetn,
  input wire [15:0] pin_in,
  output wire [15:0] pin_sync
);
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      reg stage1_reg;
      reg stage2_reg;
      // The first stage feeds only the second stage.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= pin_in[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign pin_sync[i] = stage2_reg;
    end
  endgenerate
endmodule

`default_nettype wire

// File: hw/pcn_top.v
// What this block does
// - A pin is watched only while its change-enable bit is one.
// - A remaining mismatch keeps setting the flag; clears do not stick.
// - External reset leaves the last-read latch intact; flag re-sets on mismatch.
// - A pin change during a port access may be missed.
// - With change interrupt enabled, a detected change wakes the core.
// - Port A change-enable: eight read/write bits, zero at power-on.
// - Port A pin 5 never detects while it serves as external reset.
// - Port B change-enable: bits 7-4 and 2-0 read/write, bit 3 reads zero.
// - One variant lacks port B enable bits 7-4 entirely.
// - Enabled pins compare live level with latch; mismatches OR into the flag.
// - All change enables are off after power-on reset.
// - With interrupt enable clear, the flag still sets but no request rises.
// - An analog-selected pin has no digital input and no change detection.
//
// The implementer's own choices: the address map and the APB slave port.
`include "pcn_defs.vh"
`default_nettype none

module pcn_top #(
  parameter PORT_B_UPPER = 1
) (
  input wire pclk,
  input wire presetn,
  input wire ext_reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PCN_ADDR_W-1:0] paddr,
  input wire [`PCN_DATA_W-1:0] pwdata,
  output reg [`PCN_DATA_W-1:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [`PCN_PORT_W-1:0] port_a_pins,
  input wire [`PCN_PORT_W-1:0] port_b_pins,
  output reg irq,
  output reg wake_req
);

  // Variant-dependent masks for port B.
  wire [`PCN_PORT_W-1:0] mask_b;
  wire [`PCN_PORT_W-1:0] mask_ana_b;
  assign mask_b = (PORT_B_UPPER != 0) ? `PCN_MASK_B_FULL : `PCN_MASK_B_LOW;
  assign mask_ana_b = (PORT_B_UPPER != 0) ? `PCN_MASK_ANA_B_FULL : `PCN_MASK_ANA_B_LOW;

  // Software-visible state.
  reg [`PCN_PORT_W-1:0] chg_en_a_reg;
  reg [`PCN_PORT_W-1:0] chg_en_b_reg;
  reg [`PCN_PORT_W-1:0] analog_a_reg;
  reg [`PCN_PORT_W-1:0] analog_b_reg;
  reg pin5_ext_reset_reg;
  reg change_flag_reg;
  reg change_int_enable_reg;
  reg [`PCN_PORT_W-1:0] last_a_reg;
  reg [`PCN_PORT_W-1:0] last_b_reg;

  // Next values.
  reg [`PCN_PORT_W-1:0] chg_en_a_next;
  reg [`PCN_PORT_W-1:0] chg_en_b_next;
  reg [`PCN_PORT_W-1:0] analog_a_next;
  reg [`PCN_PORT_W-1:0] analog_b_next;
  reg pin5_ext_reset_next;
  reg change_flag_next;
  reg change_int_enable_next;
  reg [`PCN_PORT_W-1:0] last_a_next;
  reg [`PCN_PORT_W-1:0] last_b_next;

  // Synchronised pins and detection results.
  wire [15:0] pin_sync;
  wire [15:0] mismatch;
  wire mismatch_any;
  wire [`PCN_PORT_W-1:0] sync_a;
  wire [`PCN_PORT_W-1:0] sync_b;
  wire [`PCN_PORT_W-1:0] eff_en_a;
  wire [`PCN_PORT_W-1:0] eff_en_b;

  // Both ports go through the synchroniser before anything looks at them.
  pcn_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({port_b_pins, port_a_pins}),
    .pin_sync(pin_sync)
  );

  assign sync_a = pin_sync[7:0];
  assign sync_b = pin_sync[15:8] & mask_b;

  // Pin 5 of port A is dropped from detection while it serves as reset input.
  assign eff_en_a = chg_en_a_reg &
    ~({{(`PCN_PORT_W-1){1'b0}}, pin5_ext_reset_reg} << `PCN_BIT_PIN5);
  assign eff_en_b = chg_en_b_reg & mask_b;

  // Comparison of live levels against the last-read latch.
  pcn_detect u_detect (
    .pin_sync({sync_b, sync_a}),
    .last_read({last_b_reg, last_a_reg}),
    .enable({eff_en_b, eff_en_a}),
    .analog({analog_b_reg, analog_a_reg}),
    .mismatch(mismatch),
    .mismatch_any(mismatch_any)
  );

  // Bus phase decode.
  wire setup_phase;
  wire access_done;
  wire wr_done;
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite;

  // Address hit decode.
  wire hit_port_a;
  wire hit_port_b;
  wire hit_en_a;
  wire hit_en_b;
  wire hit_status;
  wire hit_clear;
  wire hit_ienable;
  wire hit_config;
  wire hit_ana_a;
  wire hit_ana_b;
  wire addr_mapped;
  assign hit_port_a = (paddr == `PCN_OFF_PORT_A);
  assign hit_port_b = (paddr == `PCN_OFF_PORT_B);
  assign hit_en_a = (paddr == `PCN_OFF_CHG_EN_A);
  assign hit_en_b = (paddr == `PCN_OFF_CHG_EN_B);
  assign hit_status = (paddr == `PCN_OFF_INT_STATUS);
  assign hit_clear = (paddr == `PCN_OFF_INT_CLEAR);
  assign hit_ienable = (paddr == `PCN_OFF_INT_ENABLE);
  assign hit_config = (paddr == `PCN_OFF_CONFIG);
  assign hit_ana_a = (paddr == `PCN_OFF_ANALOG_A);
  assign hit_ana_b = (paddr == `PCN_OFF_ANALOG_B);
  assign addr_mapped = hit_port_a | hit_port_b | hit_en_a | hit_en_b |
    hit_status | hit_clear | hit_ienable | hit_config | hit_ana_a | hit_ana_b;

  // Any completed read or write of a port ends that port's mismatch.
  wire port_a_access;
  wire port_b_access;
  wire flag_clear;
  assign port_a_access = access_done & hit_port_a;
  assign port_b_access = access_done & hit_port_b;
  assign flag_clear = wr_done & hit_clear & pwdata[`PCN_BIT_CHG_FLAG];

  // Read data mux, reserved bits as zero.
  reg [`PCN_PORT_W-1:0] rd_byte;
  always @* begin
    rd_byte = {`PCN_PORT_W{1'b0}};
    if (hit_port_a) begin
      rd_byte = sync_a & ~analog_a_reg;
    end else if (hit_port_b) begin
      rd_byte = sync_b & ~analog_b_reg;
    end else if (hit_en_a) begin
      rd_byte = chg_en_a_reg;
    end else if (hit_en_b) begin
      rd_byte = chg_en_b_reg;
    end else if (hit_status) begin
      rd_byte[`PCN_BIT_CHG_FLAG] = change_flag_reg;
    end else if (hit_ienable) begin
      rd_byte[`PCN_BIT_CHG_IE] = change_int_enable_reg;
    end else if (hit_config) begin
      rd_byte[`PCN_BIT_CFG_EXTRST] = pin5_ext_reset_reg;
    end else if (hit_ana_a) begin
      rd_byte = analog_a_reg;
    end else if (hit_ana_b) begin
      rd_byte = analog_b_reg;
    end
  end

  // Next-state logic for the registers and the latch.
  always @* begin
    chg_en_a_next = chg_en_a_reg;
    chg_en_b_next = chg_en_b_reg;
    analog_a_next = analog_a_reg;
    analog_b_next = analog_b_reg;
    pin5_ext_reset_next = pin5_ext_reset_reg;
    change_int_enable_next = change_int_enable_reg;
    last_a_next = last_a_reg;
    last_b_next = last_b_reg;
    if (wr_done && hit_en_a) begin
      chg_en_a_next = pwdata[7:0] & `PCN_MASK_A;
    end
    if (wr_done && hit_en_b) begin
      chg_en_b_next = pwdata[7:0] & mask_b;
    end
    if (wr_done && hit_ana_a) begin
      analog_a_next = pwdata[7:0] & `PCN_MASK_ANA_A;
    end
    if (wr_done && hit_ana_b) begin
      analog_b_next = pwdata[7:0] & mask_ana_b;
    end
    if (wr_done && hit_config) begin
      pin5_ext_reset_next = pwdata[`PCN_BIT_CFG_EXTRST];
    end
    if (wr_done && hit_ienable) begin
      change_int_enable_next = pwdata[`PCN_BIT_CHG_IE];
    end
    // The latch takes the synchronised level seen at the access edge; a
    // change that lands in that same cycle still sets the flag at that edge.
    if (port_a_access) begin
      last_a_next = sync_a;
    end
    if (port_b_access) begin
      last_b_next = sync_b;
    end
    // A live mismatch sets the flag and wins over a clear in the same cycle.
    change_flag_next = mismatch_any | (change_flag_reg & ~flag_clear);
  end

  // Configuration and flag registers; the external reset pin returns them to their reset values.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_en_a_reg <= `PCN_RST_CHG_EN;
      chg_en_b_reg <= `PCN_RST_CHG_EN;
      analog_a_reg <= `PCN_RST_ANA_A;
      // The narrow variant powers up with only its own analog bits set.
      analog_b_reg <= (PORT_B_UPPER != 0) ? `PCN_RST_ANA_B :
        (`PCN_RST_ANA_B & `PCN_MASK_ANA_B_LOW);
      pin5_ext_reset_reg <= 1'b0;
      change_flag_reg <= 1'b0;
      change_int_enable_reg <= 1'b0;
    end else if (!ext_reset_n) begin
      chg_en_a_reg <= `PCN_RST_CHG_EN;
      chg_en_b_reg <= `PCN_RST_CHG_EN;
      analog_a_reg <= `PCN_RST_ANA_A;
      analog_b_reg <= `PCN_RST_ANA_B & mask_ana_b;
      pin5_ext_reset_reg <= 1'b0;
      change_flag_reg <= 1'b0;
      change_int_enable_reg <= 1'b0;
    end else begin
      chg_en_a_reg <= chg_en_a_next;
      chg_en_b_reg <= chg_en_b_next;
      analog_a_reg <= analog_a_next;
      analog_b_reg <= analog_b_next;
      pin5_ext_reset_reg <= pin5_ext_reset_next;
      change_flag_reg <= change_flag_next;
      change_int_enable_reg <= change_int_enable_next;
    end
  end

  // The last-read latch is cleared only at power-on and survives the pin reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_a_reg <= `PCN_RST_LATCH;
      last_b_reg <= `PCN_RST_LATCH;
    end else if (!ext_reset_n) begin
      last_a_reg <= last_a_reg;
      last_b_reg <= last_b_reg;
    end else begin
      last_a_reg <= last_a_next;
      last_b_reg <= last_b_next;
    end
  end

  // APB answer: ready one cycle after setup, so no wait states are added.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {`PCN_DATA_W{1'b0}};
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= ~addr_mapped;
      prdata <= (pwrite || !addr_mapped) ? {`PCN_DATA_W{1'b0}} :
        {{(`PCN_DATA_W-`PCN_PORT_W){1'b0}}, rd_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {`PCN_DATA_W{1'b0}};
    end
  end

  // Interrupt and wake requests follow the flag only while enabled.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq <= change_flag_reg & change_int_enable_reg;
      wake_req <= change_flag_reg & change_int_enable_reg;
    end
  end

endmodule

`default_nettype wire

// File: pkg/pcn_defs.vh
`ifndef PCN_DEFS_VH
`define PCN_DEFS_VH

// Register byte offsets on the APB bus.
`define PCN_OFF_PORT_A 8'h00
`define PCN_OFF_PORT_B 8'h04
`define PCN_OFF_CHG_EN_A 8'h08
`define PCN_OFF_CHG_EN_B 8'h0c
`define PCN_OFF_INT_STATUS 8'h10
`define PCN_OFF_INT_CLEAR 8'h14
`define PCN_OFF_INT_ENABLE 8'h18
`define PCN_OFF_CONFIG 8'h1c
`define PCN_OFF_ANALOG_A 8'h20
`define PCN_OFF_ANALOG_B 8'h24

// Address decode width and data width.
`define PCN_ADDR_W 8
`define PCN_DATA_W 32
`define PCN_PORT_W 8

// Implemented bit masks.
`define PCN_MASK_A 8'hff
`define PCN_MASK_B_FULL 8'hf7
`define PCN_MASK_B_LOW 8'h07
`define PCN_MASK_ANA_A 8'h0f
`define PCN_MASK_ANA_B_FULL 8'h36
`define PCN_MASK_ANA_B_LOW 8'h06

// Reset values.
`define PCN_RST_CHG_EN 8'h00
`define PCN_RST_ANA_A 8'h0f
`define PCN_RST_ANA_B 8'h36
`define PCN_RST_LATCH 8'h00

// Field positions.
`define PCN_BIT_CHG_FLAG 0
`define PCN_BIT_CHG_IE 0
`define PCN_BIT_CFG_EXTRST 0
`define PCN_BIT_PIN5 5

// Synchroniser depth.
`define PCN_SYNC_STAGES 2

`endif

// File: tb/pcn_pins.sv
`default_nettype none

// Pin drivers; levels move only on a clock edge, as the bench commands.
module pcn_pins (
  input wire logic pclk,
  input wire logic [7:0] a_set,
  input wire logic [7:0] b_set,
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins start low and are never moved during a port access.
  initial begin
    port_a_pins = 8'h00;
    port_b_pins = 8'h00;
  end
  // Register the commanded levels.
  always @(posedge pclk) begin
    port_a_pins <= a_set;
    port_b_pins <= b_set;
  end
endmodule

`default_nettype wire

// File: tb/pcn_properties.sv
`default_nettype none

// Watches the bus answer and the interrupt outputs of the block.
module pcn_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  input wire logic irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A completed write; a write to 0x14 or 0x18 may clear the flag or the enable.
  wire wacc = psel & penable & pwrite & pready;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // Bus answer timing and data shape.
  AST_READY: assert property (s_setup |=> s_done ##1 !pready) else $error("ready late");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  AST_B3: assert property (pready && !pwrite && (paddr == 8'h04 || paddr == 8'h0c)
    |-> !prdata[3]) else $error("bit 3 set");
  // Interrupt outputs.
  AST_WAKE: assert property (wake_req == irq) else $error("wake differs");
  AST_STICKY: assert property (irq && ext_reset_n && $past(ext_reset_n) && !wacc
    && !$past(wacc) |=> irq) else $error("irq dropped");
  AST_IE_OFF: assert property (wacc && paddr == 8'h18 && !pwdata[0]
    |-> ##2 !irq) else $error("irq while off");
endmodule

`default_nettype wire

// File: tb/tb_pin_change_interrupt.sv
`default_nettype none

module tb_pin_change_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, ext_reset_n = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, wake_req, err_q;
  logic [7:0] paddr = 8'h00, pa = 8'h00, pb = 8'h00, pina, pinb;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  int errors = 0, num_checks = 0;

  // Design, pin model and clock.
  pcn_top uut (.pclk(pclk), .presetn(presetn), .ext_reset_n(ext_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pins(pina), .port_b_pins(pinb),
    .irq(irq), .wake_req(wake_req));
  pcn_pins pins (.pclk(pclk), .a_set(pa), .b_set(pb), .port_a_pins(pina),
    .port_b_pins(pinb));
  initial forever #20 pclk = ~pclk;

  task end_sim;
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, then access held until pready is seen.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Ready, error and data are taken at the very edge that sees ready high.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) errors++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  // Move the pins, then allow synchroniser, flag and irq to settle.
  task pin(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    pa <= a;
    pb <= b;
    repeat (6) @(posedge pclk);
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h0);
    wr(8'h08, 32'hff);
    rdc(8'h08, 32'hff);
    wr(8'h0c, 32'hff);
    rdc(8'h0c, 32'hf7);
    rdc(8'h30, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h18, 32'h1);
    rdc(8'h00, 32'h0);
    pin(8'h01, 8'h00);
    rdc(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, wake_req}, 32'h1);
    wr(8'h14, 32'h1);
    rdc(8'h10, 32'h1);
    rdc(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    rdc(8'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, wake_req}, 32'h0);
    pin(8'h03, 8'h00);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h1);
    rdc(8'h10, 32'h0);
    wr(8'h18, 32'h0);
    pin(8'h01, 8'h00);
    rdc(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, wake_req}, 32'h0);
    rdc(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    // Disabled pin 1, reset-pin 5, analog pin 2 and port B bit 3 all move.
    wr(8'h08, 32'hfd);
    wr(8'h1c, 32'h1);
    wr(8'h20, 32'h04);
    pin(8'h27, 8'h08);
    rdc(8'h10, 32'h0);
    // Mismatch across an external reset: the latch keeps 0x01.
    pin(8'h26, 8'h08);
    @(posedge pclk);
    ext_reset_n <= 1'h0;
    @(posedge pclk);
    ext_reset_n <= 1'h1;
    wr(8'h08, 32'h01);
    wr(8'h20, 32'h0);
    rdc(8'h10, 32'h1);
    end_sim;
  end

  // Watchdog.
  initial begin
    repeat (4000) @(posedge pclk);
    errors++;
    end_sim;
  end
endmodule

bind pcn_top pcn_properties u_prop (.pclk(pclk), .presetn(presetn),
  .ext_reset_n(ext_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_a_pins(port_a_pins), .port_b_pins(port_b_pins), .irq(irq), .wake_req(wake_req));

`default_nettype wire
